// file: hw/swcfg_csr.sv
// Per-port configuration register bank of a packet switch.
`timescale 1ns/1ps
// Contract
// - One copy per port, 0x100 apart.
// - Found-by-host flag is read/write, resets zero.
// - Per-port 32-bit tag, read/write, resets zero.
// - Lookup misses go to the default port.
// - Default at or above port count means unmapped.
// - Unmapped default route discards the packet.
// - Bad request check only while enabled.
// - Bad reply check only while enabled.
// - Unknown request check only while enabled.
module swcfg_csr (
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // Avalon-MM register slave.
  input  wire logic [16:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output wire logic [31:0]              avs_readdata,
  output wire logic                     avs_waitrequest,
  // Routing query from the forwarding logic.
  input  wire logic                     route_req,
  input  wire logic [3:0]               route_in_port,
  input  wire logic                     route_lut_hit,
  input  wire logic [7:0]               route_lut_port,
  output wire logic                     route_valid,
  output wire logic [7:0]               route_out_port,
  output wire logic                     route_discard,
  // Raw error events from the packet decoders.
  input  wire logic                     bad_request_error,
  input  wire logic                     bad_reply_error,
  input  wire logic                     unknown_request_error,
  input  wire logic [3:0]               err_port,
  output wire logic [2:0]               err_report,
  // Status to the rest of the switch.
  output wire logic [15:0]              found_by_host_flag,
  output wire logic                     irq
);

  localparam int P  = swcfg_pkg::PORT_TOTAL;
  localparam int DW = swcfg_pkg::DATA_W;
  localparam int RW = swcfg_pkg::ROUTE_W;

  // Bus handshake state.
  swcfg_pkg::swcfg_state_t state_q, state_d;   // Handshake phase.
  logic                    waitreq_q, waitreq_d; // Registered waitrequest.
  logic [DW-1:0]           readdata_q, readdata_d; // Registered read data.

  // Register contents.
  logic [P-1:0]                         found_q, found_d;   // Found flags.
  logic [P-1:0][RW-1:0]                 route_q, route_d;   // Defaults.
  logic [P-1:0][swcfg_pkg::ERR_W-1:0]   en_q, en_d;         // Check enables.
  logic [swcfg_pkg::IRQ_W-1:0]          stat_q, stat_d;     // Sticky events.
  logic [swcfg_pkg::IRQ_W-1:0]          mask_q, mask_d;     // Event masks.
  logic                                 irq_q, irq_d;       // Interrupt.

  // Routing and error answers.
  logic                        rvalid_q, rvalid_d;      // Forward result.
  logic [RW-1:0]               rport_q, rport_d;        // Chosen port.
  logic                        rdisc_q, rdisc_d;        // Discard result.
  logic [swcfg_pkg::ERR_W-1:0] err_q, err_d;            // Gated errors.
  logic [RW-1:0]               dflt;                    // Port's default.

  // Decode and data paths.
  swcfg_pkg::swcfg_sel_t sel;       // Selected register and port.
  logic [DW-1:0]         rd_word;   // Current value of selected register.
  logic [DW-1:0]         wr_word;   // Value after a byte-enabled write.
  logic [DW-1:0]         clr_bits;  // Bits a status write clears.
  logic                  commit_wr; // Write takes effect this edge.
  logic                  gen_wr;    // Write to a general control copy.

  // Tag memory link.
  swcfg_tag_if tag_bus ();

  assign sel       = swcfg_pkg::decode(avs_address);
  assign commit_wr = (state_q == swcfg_pkg::ST_ACK) && avs_write;
  assign gen_wr    = commit_wr && (sel.kind == swcfg_pkg::R_GEN);
  assign wr_word   = swcfg_pkg::merge(rd_word, avs_writedata, avs_byteenable);
  assign clr_bits  = avs_writedata & swcfg_pkg::be_mask(avs_byteenable);

  // Tag writes commit at the same edge as every other write.
  assign tag_bus.we    = commit_wr && (sel.kind == swcfg_pkg::R_TAG);
  assign tag_bus.addr  = sel.port;
  assign tag_bus.wdata = avs_writedata;
  assign tag_bus.be    = avs_byteenable;

  swcfg_tag_mem u_tag_mem (
    .core_clk (core_clk),
    .reset    (reset),
    .tag      (tag_bus.mem)
  );

  // Builds the selected register's read value; every unnamed bit is zero.
  always_comb begin
    rd_word = '0;
    unique case (sel.kind)
      swcfg_pkg::R_NONE: begin
        rd_word = '0;
      end
      swcfg_pkg::R_GEN: begin
        rd_word[swcfg_pkg::FOUND_POS] = found_q[sel.port];
      end
      swcfg_pkg::R_TAG: begin
        rd_word = tag_bus.rdata;
      end
      swcfg_pkg::R_ROUTE: begin
        rd_word[swcfg_pkg::ROUTE_POS +: RW] = route_q[sel.port];
      end
      swcfg_pkg::R_ERR: begin
        rd_word[swcfg_pkg::BAD_REQ_POS] =
          en_q[sel.port][swcfg_pkg::ERR_BAD_REQ];
        rd_word[swcfg_pkg::BAD_REPLY_POS] =
          en_q[sel.port][swcfg_pkg::ERR_BAD_REPLY];
        rd_word[swcfg_pkg::UNKNOWN_POS] =
          en_q[sel.port][swcfg_pkg::ERR_UNKNOWN];
      end
      swcfg_pkg::R_STAT: begin
        rd_word[swcfg_pkg::IRQ_W-1:0] = stat_q;
      end
      swcfg_pkg::R_MASK: begin
        rd_word[swcfg_pkg::IRQ_W-1:0] = mask_q;
      end
    endcase
  end

  // Handshake: seen in idle, read data fetched, then one cycle with
  // waitrequest low in which the master completes.
  always_comb begin
    state_d    = state_q;
    waitreq_d  = waitreq_q;
    readdata_d = readdata_q;
    unique case (state_q)
      swcfg_pkg::ST_IDLE: begin
        if (avs_read || avs_write) begin
          state_d = swcfg_pkg::ST_FETCH;
        end
      end
      swcfg_pkg::ST_FETCH: begin
        state_d    = swcfg_pkg::ST_ACK;
        waitreq_d  = 1'h0;
        readdata_d = avs_read ? rd_word : '0;
      end
      swcfg_pkg::ST_ACK: begin
        state_d   = swcfg_pkg::ST_IDLE;
        waitreq_d = 1'h1;
      end
      default: begin
        state_d   = swcfg_pkg::ST_IDLE;
        waitreq_d = 1'h1;
      end
    endcase
  end

  // Registers the handshake; waitrequest stays high while idle.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q    <= swcfg_pkg::ST_IDLE;
      waitreq_q  <= 1'h1;
      readdata_q <= '0;
    end else begin
      state_q    <= state_d;
      waitreq_q  <= waitreq_d;
      readdata_q <= readdata_d;
    end
  end

  // Routing: lookup hits pass through, misses take the ingress port's
  // default, and a default beyond the last port drops the packet.
  always_comb begin
    dflt     = route_q[route_in_port];
    rvalid_d = 1'h0;
    rdisc_d  = 1'h0;
    rport_d  = rport_q;
    if (route_req) begin
      if (route_lut_hit) begin
        rvalid_d = 1'h1;
        rport_d  = route_lut_port;
      end else if (dflt >= RW'(P)) begin
        rdisc_d = 1'h1;
      end else begin
        rvalid_d = 1'h1;
        rport_d  = dflt;
      end
    end
  end

  // Error events pass only while the reporting port's check is enabled.
  always_comb begin
    err_d = '0;
    err_d[swcfg_pkg::ERR_BAD_REQ] = bad_request_error &&
      en_q[err_port][swcfg_pkg::ERR_BAD_REQ];
    err_d[swcfg_pkg::ERR_BAD_REPLY] = bad_reply_error &&
      en_q[err_port][swcfg_pkg::ERR_BAD_REPLY];
    err_d[swcfg_pkg::ERR_UNKNOWN] = unknown_request_error &&
      en_q[err_port][swcfg_pkg::ERR_UNKNOWN];
  end

  // Registers the routing and error answers; valid, discard and errors as one-cycle pulses, the chosen port held.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'h0;
      rport_q  <= swcfg_pkg::ROUTE_RST;
      rdisc_q  <= 1'h0;
      err_q    <= '0;
    end else begin
      rvalid_q <= rvalid_d;
      rport_q  <= rport_d;
      rdisc_q  <= rdisc_d;
      err_q    <= err_d;
    end
  end

  // Applies software writes; an event arriving with a status clear wins.
  always_comb begin
    found_d = found_q;
    route_d = route_q;
    en_d    = en_q;
    stat_d  = stat_q;
    mask_d  = mask_q;
    if (commit_wr) begin
      unique case (sel.kind)
        swcfg_pkg::R_NONE, swcfg_pkg::R_TAG: begin
          stat_d = stat_q;
        end
        swcfg_pkg::R_GEN: begin
          found_d[sel.port] = wr_word[swcfg_pkg::FOUND_POS];
        end
        swcfg_pkg::R_ROUTE: begin
          route_d[sel.port] = wr_word[swcfg_pkg::ROUTE_POS +: RW];
        end
        swcfg_pkg::R_ERR: begin
          en_d[sel.port] = {wr_word[swcfg_pkg::UNKNOWN_POS],
                            wr_word[swcfg_pkg::BAD_REPLY_POS],
                            wr_word[swcfg_pkg::BAD_REQ_POS]};
        end
        swcfg_pkg::R_STAT: begin
          stat_d = stat_q & ~clr_bits[swcfg_pkg::IRQ_W-1:0];
        end
        swcfg_pkg::R_MASK: begin
          mask_d = wr_word[swcfg_pkg::IRQ_W-1:0];
        end
      endcase
    end
    stat_d = stat_d | {rdisc_d, err_d};
    irq_d  = |(stat_d & mask_d);
  end

  // Holds the register contents with their reset values.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      found_q <= {P{swcfg_pkg::FOUND_RST}};
      route_q <= {P{swcfg_pkg::ROUTE_RST}};
      en_q    <= {P{swcfg_pkg::ERR_RST}};
      stat_q  <= swcfg_pkg::IRQ_RST;
      mask_q  <= swcfg_pkg::IRQ_RST;
      irq_q   <= 1'h0;
    end else begin
      found_q <= found_d;
      route_q <= route_d;
      en_q    <= en_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
    end
  end

  assign avs_readdata       = readdata_q;
  assign avs_waitrequest    = waitreq_q;
  assign route_valid        = rvalid_q;
  assign route_out_port     = rport_q;
  assign route_discard      = rdisc_q;
  assign err_report         = err_q;
  assign found_by_host_flag = found_q;
  assign irq                = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A request seen while idle, then the two-step answer.
  sequence s_req_seen;
    state_q == swcfg_pkg::ST_IDLE && (avs_read || avs_write);
  endsequence
  sequence s_answer;
    waitreq_q ##1 !waitreq_q ##1 waitreq_q;
  endsequence

  a_bus_answer: assert property (s_req_seen |=> s_answer)
    else $error("Bus answer not two cycles after request.");

  a_found_write: assert property (
    gen_wr && avs_byteenable[swcfg_pkg::FOUND_BYTE] |=>
    found_q[$past(sel.port)] == $past(avs_writedata[swcfg_pkg::FOUND_POS]))
    else $error("Found flag write lost.");

  a_found_steady: assert property (
    $changed(found_q) |-> $past(gen_wr))
    else $error("Found flag changed without a write.");

  a_port_isolated: assert property (
    gen_wr |=> ((found_q ^ $past(found_q)) &
      ~({{(P-1){1'h0}}, 1'h1} << $past(sel.port))) == '0)
    else $error("Write touched another port's copy.");

  a_tag_readback: assert property (
    state_q == swcfg_pkg::ST_ACK && avs_read &&
    sel.kind == swcfg_pkg::R_TAG |-> readdata_q == $past(tag_bus.rdata))
    else $error("Tag read returned wrong data.");

  a_route_default: assert property (
    route_req && !route_lut_hit && route_q[route_in_port] < RW'(P) |=>
    route_valid && route_out_port == $past(route_q[route_in_port]))
    else $error("Miss not sent to default port.");

  a_route_unmapped: assert property (
    route_req && !route_lut_hit && route_q[route_in_port] >= RW'(P) |=>
    route_discard && !route_valid ##1
    (!route_discard || $past(route_req && !route_lut_hit)))
    else $error("Unmapped default not treated as unmapped.");

  a_discard_cause: assert property (
    route_discard |-> $past(route_req && !route_lut_hit) && !route_valid)
    else $error("Discard without a default route miss.");

  a_bad_req_gate: assert property (
    bad_request_error |=> err_report[swcfg_pkg::ERR_BAD_REQ] ==
    $past(en_q[err_port][swcfg_pkg::ERR_BAD_REQ]))
    else $error("Bad request check ignored its enable.");

  a_bad_reply_gate: assert property (
    err_report[swcfg_pkg::ERR_BAD_REPLY] |->
    $past(bad_reply_error && en_q[err_port][swcfg_pkg::ERR_BAD_REPLY]))
    else $error("Bad reply reported while disabled.");

  a_unknown_gate: assert property (
    unknown_request_error && !en_q[err_port][swcfg_pkg::ERR_UNKNOWN] |=>
    !err_report[swcfg_pkg::ERR_UNKNOWN] &&
    !$rose(stat_q[swcfg_pkg::ERR_UNKNOWN]))
    else $error("Unknown request reported while disabled.");

  a_reserved_zero: assert property (
    state_q == swcfg_pkg::ST_ACK && avs_read && sel.kind == swcfg_pkg::R_GEN
    |-> (readdata_q & ~(32'h1 << swcfg_pkg::FOUND_POS)) == 32'h0)
    else $error("Reserved general control bits read nonzero.");

endmodule // swcfg_csr

// file: inc/swcfg_pkg.sv
// Constants, types and helpers of the per-port switch configuration bank.
package swcfg_pkg;

  // Geometry of the bank.
  localparam int PORT_TOTAL = 16;           // Ports that each own a copy.
  localparam int PORT_W     = 4;            // Width of a port number.
  localparam int ADDR_W     = 17;           // Avalon byte address width.
  localparam int DATA_W     = 32;           // Avalon data width.
  localparam int BE_W       = DATA_W / 8;   // Byte enables per word.
  localparam int PORT_LSB   = 8;            // Copies sit 0x100 apart.
  localparam int ROUTE_W    = 8;            // Default output port width.
  localparam int ERR_W      = 3;            // Error detection enables.
  localparam int IRQ_W      = 4;            // Interrupt status bits.

  // Byte addresses of port 0's copies and of the interrupt registers.
  localparam logic [ADDR_W-1:0] GEN_CTL_OFS  = 17'h1603c;
  localparam logic [ADDR_W-1:0] TAG_OFS      = 17'h1606c;
  localparam logic [ADDR_W-1:0] ROUTE_OFS    = 17'h16078;
  localparam logic [ADDR_W-1:0] ERR_EN_OFS   = 17'h1607c;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 17'h17000;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 17'h17004;

  // Turns a bit number counted from the most significant end into a
  // vector index.
  function automatic int bitpos(input int msb0);
    return DATA_W - 1 - msb0;
  endfunction

  // Field positions, given as the printed big-endian bit numbers.
  localparam int FOUND_POS     = bitpos(2);
  localparam int BAD_REQ_POS   = bitpos(4);
  localparam int BAD_REPLY_POS = bitpos(8);
  localparam int UNKNOWN_POS   = bitpos(9);
  localparam int ROUTE_POS     = bitpos(31);
  localparam int FOUND_BYTE    = FOUND_POS / 8;

  // Index of each error kind in the enables and in interrupt status.
  localparam int ERR_BAD_REQ   = 0;
  localparam int ERR_BAD_REPLY = 1;
  localparam int ERR_UNKNOWN   = 2;
  localparam int IRQ_DISCARD   = 3;

  // Reset values.
  localparam logic               FOUND_RST = 1'h0;
  localparam logic [DATA_W-1:0]  TAG_RST   = 32'h0;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 8'hff;
  localparam logic [ERR_W-1:0]   ERR_RST   = 3'h0;
  localparam logic [IRQ_W-1:0]   IRQ_RST   = 4'h0;

  // Bus handshake states, Gray coded along idle, fetch, acknowledge.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_ACK   = 2'h3
  } swcfg_state_t;

  // Register selected by an address.
  typedef enum logic [2:0] {
    R_NONE, R_GEN, R_TAG, R_ROUTE, R_ERR, R_STAT, R_MASK
  } swcfg_reg_t;

  // Decoded address: register kind and owning port.
  typedef struct packed {
    swcfg_reg_t        kind;
    logic [PORT_W-1:0] port;
  } swcfg_sel_t;

  // Maps a byte address onto a register; port n's copy is 0x100 above
  // port n-1's copy.
  function automatic swcfg_sel_t decode(input logic [ADDR_W-1:0] a);
    swcfg_sel_t s;
    s.kind = R_NONE;
    s.port = a[PORT_LSB +: PORT_W];
    if (a == IRQ_STAT_OFS) begin
      s.kind = R_STAT;
    end else if (a == IRQ_MASK_OFS) begin
      s.kind = R_MASK;
    end else if (a[ADDR_W-1:PORT_LSB+PORT_W] ==
                 GEN_CTL_OFS[ADDR_W-1:PORT_LSB+PORT_W]) begin
      if (a[PORT_LSB-1:0] == GEN_CTL_OFS[PORT_LSB-1:0]) s.kind = R_GEN;
      if (a[PORT_LSB-1:0] == TAG_OFS[PORT_LSB-1:0]) s.kind = R_TAG;
      if (a[PORT_LSB-1:0] == ROUTE_OFS[PORT_LSB-1:0]) s.kind = R_ROUTE;
      if (a[PORT_LSB-1:0] == ERR_EN_OFS[PORT_LSB-1:0]) s.kind = R_ERR;
    end
    return s;
  endfunction

  // Expands byte enables into a bit mask.
  function automatic logic [DATA_W-1:0] be_mask(input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Replaces the enabled bytes of an old word by new data.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [BE_W-1:0] be);
    return (o & ~be_mask(be)) | (n & be_mask(be));
  endfunction

endpackage

// file: inc/swcfg_tag_if.sv
// Link between the bank's control logic and its component tag memory.
`timescale 1ns/1ps
interface swcfg_tag_if;
  logic                                we;     // Write strobe.
  logic [swcfg_pkg::PORT_W-1:0]        addr;   // Port whose tag is used.
  logic [swcfg_pkg::DATA_W-1:0]        wdata;  // Write data.
  logic [swcfg_pkg::BE_W-1:0]          be;     // Byte enables.
  logic [swcfg_pkg::DATA_W-1:0]        rdata;  // Registered read data.

  // Control side drives requests.
  modport ctrl (output we, addr, wdata, be, input rdata);
  // Memory side answers them.
  modport mem (input we, addr, wdata, be, output rdata);
endinterface

// file: hw/swcfg_tag_mem.sv
// Sixteen-word component tag memory with registered read data.
`timescale 1ns/1ps
module swcfg_tag_mem (
  // Clock and reset.
  input wire logic      core_clk,
  input wire logic      reset,
  // Access from the control logic.
  swcfg_tag_if.mem      tag
);

  localparam int P = swcfg_pkg::PORT_TOTAL;

  logic [P-1:0][swcfg_pkg::DATA_W-1:0] mem_q, mem_d;     // Stored tags.
  logic [swcfg_pkg::DATA_W-1:0]        rdata_q, rdata_d; // Read register.

  // Merges enabled bytes into the addressed word and reads it back.
  always_comb begin
    mem_d = mem_q;
    if (tag.we) begin
      mem_d[tag.addr] = swcfg_pkg::merge(mem_q[tag.addr], tag.wdata,
                                         tag.be);
    end
    rdata_d = mem_q[tag.addr];
  end

  // Holds the tags, all zero after reset.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_q   <= {P{swcfg_pkg::TAG_RST}};
      rdata_q <= swcfg_pkg::TAG_RST;
    end else begin
      mem_q   <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign tag.rdata = rdata_q;

  // A full-word write lands in the addressed entry.
  a_tag_write_lands: assert property (
    @(posedge core_clk) disable iff (reset)
    tag.we && tag.be == 4'hf |=> mem_q[$past(tag.addr)] == $past(tag.wdata))
    else $error("Tag write did not land.");

endmodule // swcfg_tag_mem

// file: bench/swcfg_csr_bench.sv
// Self-checking bench of the per-port switch configuration bank.
`timescale 1ns/1ps
module swcfg_csr_bench;
  // Stimulus and observed signals of the bank.
  logic        core_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [16:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, route_in_port, err_port;
  logic        route_req, route_lut_hit, route_valid, route_discard, irq;
  logic [7:0]  route_lut_port, route_out_port;
  logic [2:0]  err_v, err_report;
  logic [15:0] found_by_host_flag, fv;
  // Bench model of every port's copy, plus counters.
  logic        found_m[16];
  logic [31:0] tag_m[16];
  logic [7:0]  route_m[16];
  logic [2:0]  err_m[16];
  logic [16:0] ofs[4];
  int          n_fail, cmp_count, cyc, k, p;
  logic [7:0]  rv[5];

  swcfg_csr swcfg_csr_i (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .route_req(route_req), .route_in_port(route_in_port),
    .route_lut_hit(route_lut_hit), .route_lut_port(route_lut_port),
    .route_valid(route_valid), .route_out_port(route_out_port),
    .route_discard(route_discard), .bad_request_error(err_v[0]),
    .bad_reply_error(err_v[1]), .unknown_request_error(err_v[2]),
    .err_port(err_port), .err_report(err_report),
    .found_by_host_flag(found_by_host_flag), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // Compares one observed word with its expected value.
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Vector mask of a bit numbered from the most significant end.
  function automatic logic [31:0] msb(input int n);
    return 32'h8000_0000 >> n;
  endfunction

  // Expected read value of register kind c of port n.
  function automatic logic [31:0] exp_reg(input int c, input int n);
    case (c)
      0: return found_m[n] ? msb(2) : 32'h0;
      1: return tag_m[n];
      2: return {24'h0, route_m[n]};
      default: return (err_m[n][0] ? msb(4) : 32'h0) |
        (err_m[n][1] ? msb(8) : 32'h0) | (err_m[n][2] ? msb(9) : 32'h0);
    endcase
  endfunction

  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [16:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    // Only the bench's cycle ceiling ends a wait that never answers.
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  // Writes a register through byte lanes and updates the model.
  task automatic wr_reg(input int c, input int n, input logic [31:0] d,
      input logic [3:0] be);
    logic [31:0] m, w;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
    w = (exp_reg(c, n) & ~m) | (d & m);
    bus(1'h1, ofs[c] + 17'(n * 256), d, be);
    case (c)
      0: found_m[n] = |(w & msb(2));
      1: tag_m[n] = w;
      2: route_m[n] = w[7:0];
      default: err_m[n] = {|(w & msb(9)), |(w & msb(8)), |(w & msb(4))};
    endcase
  endtask

  // Reads a register and compares it with the model.
  task automatic rd_chk(input int c, input int n);
    bus(1'h0, ofs[c] + 17'(n * 256), 32'h0, 4'hf);
    chk("register", exp_reg(c, n), q);
  endtask

  // Issues a routing query and checks the answer one cycle later.
  task automatic route_chk(input int n, input logic hit);
    logic [7:0] lp, ep;
    lp = 8'($urandom_range(15));
    ep = hit ? lp : route_m[n];
    @(posedge core_clk);
    route_req      <= 1'h1;
    route_in_port  <= 4'(n);
    route_lut_hit  <= hit;
    route_lut_port <= lp;
    @(posedge core_clk);
    route_req <= 1'h0;
    #1;
    chk("route_discard", {31'h0, ep > 8'h0f}, {31'h0, route_discard});
    chk("route_valid", {31'h0, ep <= 8'h0f}, {31'h0, route_valid});
    if (ep <= 8'h0f) begin
      chk("route_out_port", {24'h0, ep}, {24'h0, route_out_port});
    end
  endtask

  // Pulses one error kind on a port and checks the report.
  task automatic err_chk(input int c, input int n, input logic [2:0] e);
    @(posedge core_clk);
    err_v    <= 3'(1 << c);
    err_port <= 4'(n);
    @(posedge core_clk);
    err_v <= 3'h0;
    #1;
    chk("err_report", {29'h0, e}, {29'h0, err_report});
  endtask

  // Checks irq once the status change has settled.
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Main sequence.
  initial begin
    {reset, avs_read, avs_write, route_req, route_lut_hit} = 5'h10;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {route_in_port, route_lut_port, err_v, err_port} = '0;
    {n_fail, cmp_count, cyc} = '0;
    ofs = '{swcfg_pkg::GEN_CTL_OFS, swcfg_pkg::TAG_OFS,
      swcfg_pkg::ROUTE_OFS, swcfg_pkg::ERR_EN_OFS};
    rv = '{8'h00, 8'h0f, 8'h10, 8'hff, 8'h07};
    for (int i = 0; i < 16; i++) begin
      {found_m[i], tag_m[i]} = {1'h0, 32'h0};
      {route_m[i], err_m[i]} = {8'hff, 3'h0};
    end
    void'($urandom(32'hdc5c));
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    // Reset value of every copy of every per-port register.
    for (int i = 0; i < 64; i++) begin
      rd_chk(i % 4, i / 4);
    end
    // Random writes with random byte lanes, each read back.
    repeat (80) begin
      k = $urandom_range(3);
      p = $urandom_range(15);
      wr_reg(k, p, $urandom, 4'($urandom_range(1, 15)));
      rd_chk(k, p);
    end
    // The configuring host marks one port as found after discovery.
    wr_reg(0, 5, msb(2), 4'h8);
    for (int i = 0; i < 64; i++) rd_chk(i % 4, i / 4);
    for (int i = 0; i < 16; i++) fv[i] = found_m[i];
    chk("found_flags", {16'h0, fv}, {16'h0, found_by_host_flag});
    // An unmapped address ignores a write and reads as zero.
    bus(1'h1, 17'h16040, 32'hffff_ffff, 4'hf);
    bus(1'h0, 17'h16040, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    // Default route at the port count boundary, mapped and unmapped.
    bus(1'h1, swcfg_pkg::IRQ_MASK_OFS, 32'hf, 4'hf);
    for (int i = 0; i < 5; i++) begin
      p = $urandom_range(15);
      wr_reg(2, p, {24'h0, rv[i]}, 4'h1);
      route_chk(p, 1'h0);
      route_chk(p, 1'h1);
    end
    bus(1'h0, swcfg_pkg::IRQ_STAT_OFS, 32'h0, 4'hf);
    chk("discard_status", 32'h8, q);
    // Error reports off, then on, with interrupt cleared, set, masked.
    for (int c = 0; c < 3; c++) begin
      p = $urandom_range(15);
      wr_reg(3, p, 32'h0, 4'hf);
      err_chk(c, p, 3'h0);
      wr_reg(3, p, msb(4) | msb(8) | msb(9), 4'hf);
      bus(1'h1, swcfg_pkg::IRQ_STAT_OFS, 32'hf, 4'hf);
      irq_chk(1'h0);
      err_chk(c, p, 3'(1 << c));
      bus(1'h0, swcfg_pkg::IRQ_STAT_OFS, 32'h0, 4'hf);
      chk("status", 32'(1 << c), q);
      irq_chk(1'h1);
      bus(1'h1, swcfg_pkg::IRQ_MASK_OFS, 32'h0, 4'hf);
      irq_chk(1'h0);
      bus(1'h1, swcfg_pkg::IRQ_MASK_OFS, 32'hf, 4'hf);
    end
    tally_and_finish;
  end
endmodule // swcfg_csr_bench
